// File: verilog/lcdr_display_map.sv
// Display RAM write path with input FIFO, display register and output pin mapping.
module lcdr_fifo
  import lcdr_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      count <= '0;
      in_ready_o <= 1'b0;
    end else begin
      count <= next_count;
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + AW'(1);
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + AW'(1);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wptr] <= in_data_i;
    end
  end

  property p_full_block;
    @(posedge clock_i) disable iff (!resetn_i) count == (AW+1)'(DEPTH) |-> !in_ready_o;
  endproperty
  a_full_block: assert property (p_full_block) else $error("fifo full but ready");

endmodule

module lcdr_display_map
  import lcdr_pkg::*;
#(
  parameter int unsigned ROW_DIV = ROW_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Configuration
  input wire lcdr_mode_t mode_i,
  input wire logic input_bank_select_i,
  input wire logic output_bank_select_i,
  // Decoded host stream
  input wire logic host_valid_i,
  input wire lcdr_host_t host_word_i,
  output logic host_ready_o,
  // Panel pins
  output lcdr_pins_t pins_o
);
  logic fifo_valid;
  lcdr_host_t fifo_word;
  logic drain_ready;
  logic drain;

  logic [NUM_COLS-1:0][NUM_ROWS-1:0] ram;
  logic [NUM_COLS-1:0][NUM_ROWS-1:0] disp_reg;
  logic [PTR_W-1:0] ptr_col;
  logic [ROW_W-1:0] ptr_sub;
  logic [PTR_W-1:0] next_col;
  logic [ROW_W-1:0] next_sub;
  logic [PTR_W-1:0] wr_col [BYTE_BITS];
  logic [ROW_W-1:0] wr_row [BYTE_BITS];
  logic [BYTE_BITS-1:0] wr_en;
  logic [PTR_W-1:0] lim;
  logic [PTR_W-1:0] load_col;
  logic [3:0] h;

  logic [DIV_W-1:0] div_cnt;
  logic tick;
  logic [ROW_W-1:0] phase;
  logic frame_start;
  logic [ROW_W-1:0] act_phase;
  logic [ROW_W-1:0] rd_row;
  logic [NUM_ROWS-1:0] next_bp;
  logic [NUM_COLS-1:0] next_seg;

  lcdr_fifo #(
    .WIDTH($bits(lcdr_host_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .in_valid_i(host_valid_i),
    .in_data_i(host_word_i),
    .in_ready_o(host_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_word),
    .out_ready_i(drain_ready)
  );

  // Writes pause in the cycle the frame is copied so a snapshot never splits a byte's order.
  assign drain_ready = !frame_start;
  assign drain = fifo_valid && drain_ready;
  assign h = rows_per_col(mode_i);
  assign lim = col_limit(mode_i);
  assign load_col = fifo_word.value[PTR_W-1:0];

  // Walks the byte MSB first through rows of the current column, then on to the next.
  always_comb begin
    logic [PTR_W-1:0] c;
    logic [ROW_W-1:0] r;
    c = ptr_col;
    r = ptr_sub;
    for (int j = 0; j < BYTE_BITS; j++) begin
      wr_col[j] = c;
      wr_row[j] = ROW_W'(bank_row(mode_i, input_bank_select_i) + r);
      wr_en[j] = (c < lim);
      if (c < lim) begin
        if ({1'b0, r} == h - 4'h1) begin
          r = '0;
          c = c + 6'h01;
        end else begin
          r = r + 3'h1;
        end
      end
    end
    next_col = c;
    next_sub = r;
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ptr_col <= '0;
      ptr_sub <= '0;
    end else if (drain && fifo_word.load_ptr) begin
      ptr_col <= load_col;
      ptr_sub <= '0;
    end else if (drain) begin
      ptr_col <= next_col;
      ptr_sub <= next_sub;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ram <= '0;
    end else if (drain && !fifo_word.load_ptr) begin
      for (int j = 0; j < BYTE_BITS; j++) begin
        if (wr_en[j]) begin
          ram[wr_col[j]][wr_row[j]] <= fifo_word.value[BYTE_BITS-1-j];
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (div_cnt == DIV_W'(ROW_DIV - 1)) begin
      div_cnt <= '0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  assign frame_start = tick && ({1'b0, phase} >= h - 4'h1);

  // A phase left over from a wider mode shows as phase 0 until the next tick wraps it.
  assign act_phase = ({1'b0, phase} >= h) ? '0 : phase;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      phase <= '0;
    end else if (frame_start) begin
      phase <= '0;
    end else if (tick) begin
      phase <= phase + 3'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      disp_reg <= '0;
    end else if (frame_start) begin
      disp_reg <= ram;
    end
  end

  assign rd_row = ROW_W'(bank_row(mode_i, output_bank_select_i) + act_phase);

  for (genvar i = 0; i < NUM_ROWS; i++) begin : g_bp
    assign next_bp[i] = ({1'b0, act_phase} == 4'(i % int'(h)));
  end

  for (genvar k = 0; k < NUM_COLS; k++) begin : g_seg
    assign next_seg[k] = disp_reg[k][rd_row];
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pins_o <= '0;
    end else begin
      pins_o.backplane <= next_bp[5:0];
      pins_o.seg45_bp6 <= (mode_i == MODE_SEX) ? next_seg[45] : next_bp[6];
      pins_o.seg44_bp7 <= (mode_i == MODE_SEX) ? next_seg[44] : next_bp[7];
      pins_o.segment <= next_seg[STD_COLS-1:0];
    end
  end

  logic [NUM_ROWS-1:0] bp_all;
  logic sh45_src;
  assign bp_all = {pins_o.seg44_bp7, pins_o.seg45_bp6, pins_o.backplane};
  assign sh45_src = disp_reg[45][rd_row];

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_load;
    drain && fifo_word.load_ptr;
  endsequence

  sequence s_data;
    drain && !fifo_word.load_ptr;
  endsequence

  property p_load;
    s_load |=> ptr_col == $past(load_col) && ptr_sub == 3'h0;
  endproperty
  a_load: assert property (p_load) else $error("pointer load not taken");

  property p_static_step;
    s_data ##0 (mode_i == MODE_STATIC && ptr_col <= PTR_W'(STD_COLS - STATIC_STEP))
      |=> ptr_col == $past(ptr_col) + 6'h08;
  endproperty
  a_static_step: assert property (p_static_step) else $error("static step wrong");

  property p_oct_step;
    s_data ##0 (mode_i == MODE_OCT && ptr_sub == 3'h0 && ptr_col < lim)
      |=> ptr_col == $past(ptr_col) + 6'h01 && ptr_sub == 3'h0;
  endproperty
  a_oct_step: assert property (p_oct_step) else $error("1:8 step wrong");

  property p_dup_step;
    s_data ##0 (mode_i == MODE_DUP && ptr_sub == 3'h0 &&
      ptr_col <= PTR_W'(STD_COLS - BYTE_BITS / 2))
      |=> ptr_col == $past(ptr_col) + PTR_W'(BYTE_BITS / 2) && ptr_sub == 3'h0;
  endproperty
  a_dup_step: assert property (p_dup_step) else $error("1:2 step wrong");

  property p_quad_step;
    s_data ##0 (mode_i == MODE_QUAD && ptr_sub == 3'h0 &&
      ptr_col <= PTR_W'(STD_COLS - BYTE_BITS / 4))
      |=> ptr_col == $past(ptr_col) + PTR_W'(BYTE_BITS / 4) && ptr_sub == 3'h0;
  endproperty
  a_quad_step: assert property (p_quad_step) else $error("1:4 step wrong");

  property p_sex_step;
    s_data ##0 (mode_i == MODE_SEX && ptr_col < PTR_W'(NUM_COLS - 2))
      |=> ptr_col == $past(ptr_col) + 6'h01 || ptr_col == $past(ptr_col) + 6'h02;
  endproperty
  a_sex_step: assert property (p_sex_step) else $error("1:6 step not one or two");

  property p_bank_write;
    s_data ##0 (mode_i == MODE_STATIC && input_bank_select_i && ptr_col < lim)
      |=> ram[$past(ptr_col)][BANK1_ROW] == $past(fifo_word.value[BYTE_BITS-1]);
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank 1 write missed");

  property p_stop;
    s_data ##0 (ptr_col >= lim) |=> $stable(ptr_col) && $stable(ptr_sub);
  endproperty
  a_stop: assert property (p_stop) else $error("pointer moved past row end");

  property p_hold;
    !frame_start |=> $stable(disp_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("display register changed mid frame");

  property p_oct_bp;
    $past(resetn_i) && $past(mode_i) == MODE_OCT |-> $onehot(bp_all);
  endproperty
  a_oct_bp: assert property (p_oct_bp) else $error("1:8 phases not distinct");

  property p_quad_bp;
    $past(resetn_i) && $past(mode_i) == MODE_QUAD |->
      bp_all[7:4] == bp_all[3:0];
  endproperty
  a_quad_bp: assert property (p_quad_bp) else $error("1:4 repeat wrong");

  property p_dup_bp;
    $past(resetn_i) && $past(mode_i) == MODE_DUP |->
      bp_all == {4{bp_all[1:0]}};
  endproperty
  a_dup_bp: assert property (p_dup_bp) else $error("1:2 repeat wrong");

  property p_static_bp;
    $past(resetn_i) && $past(mode_i) == MODE_STATIC |-> &bp_all;
  endproperty
  a_static_bp: assert property (p_static_bp) else $error("static phase missing");

  property p_sex_seg;
    $past(resetn_i) && $past(mode_i) == MODE_SEX |-> pins_o.seg45_bp6 == $past(sh45_src);
  endproperty
  a_sex_seg: assert property (p_sex_seg) else $error("1:6 shared pin not segment");

endmodule

// File: verilog/lcdr_pkg.sv
// Constants, types and decode functions for the LCD display RAM and output map.
// Behaviour
// - Backplane outputs follow the selected drive mode.
// - 1:8 drives eight distinct phases on outputs 0-7.
// - 1:6 uses outputs 0-5; shared pins carry segments.
// - 1:4 repeats phases 0-3 on outputs 4-7.
// - 1:2 puts phase 0 on even, 1 on odd.
// - Static drives one phase on all eight outputs.
// - Segment outputs 0-43 are segments in every mode.
// - Segment level combines phase timing with column bit.
// - Display register holds data stable during frame.
// - RAM shape depends on mode: 44 or 46 columns.
// - Lower modes split RAM into banks at row 4.
// - Stored one lights element, zero blanks it.
// - Row n pairs phase n; column k feeds segment k.
// - Each byte is written on arrival at pointer.
// - Pointer load sets the address for following bytes.
// - Pointer step per byte depends on mode.
// - Pointer stops at row end; surplus bits dropped.
// - Static byte fills eight columns of one row.
// - 1:2 byte fills four columns of two rows.
// - 1:4 byte fills two columns of four rows.
// - Static bank 1 writes go to row 4.
// - Bank 1 uses row 4, rows 4-5 or rows 4-7.
// - 1:6 starts at row 0 and wraps columns.
// - 1:8 byte fills one whole column.
// - Output bank bit picks displayed bank.
package lcdr_pkg;

  localparam int NUM_ROWS = 8;
  localparam int NUM_COLS = 46;
  localparam int STD_COLS = 44;
  localparam int BYTE_BITS = 8;
  localparam int PTR_W = 6;
  localparam int ROW_W = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int DIV_W = 16;
  localparam int STATIC_STEP = 8;
  localparam logic [ROW_W-1:0] BANK1_ROW = 3'h4;
  localparam int CLK_HZ = 10_000_000;
  localparam int ROW_TIME_US = 1250;
  localparam int ROW_CYCLES = CLK_HZ / 1_000_000 * ROW_TIME_US;

  typedef enum logic [4:0] {
    MODE_STATIC = 5'h01,
    MODE_DUP = 5'h02,
    MODE_QUAD = 5'h04,
    MODE_SEX = 5'h08,
    MODE_OCT = 5'h10
  } lcdr_mode_t;

  typedef struct packed {
    logic load_ptr;
    logic [BYTE_BITS-1:0] value;
  } lcdr_host_t;

  typedef struct packed {
    logic [5:0] backplane;
    logic seg45_bp6;
    logic seg44_bp7;
    logic [STD_COLS-1:0] segment;
  } lcdr_pins_t;

  // Number of RAM rows that one column holds, which is also the phase count.
  function automatic logic [3:0] rows_per_col(input lcdr_mode_t mode);
    unique case (mode)
      MODE_STATIC: rows_per_col = 4'h1;
      MODE_DUP: rows_per_col = 4'h2;
      MODE_QUAD: rows_per_col = 4'h4;
      MODE_SEX: rows_per_col = 4'h6;
      MODE_OCT: rows_per_col = 4'h8;
      default: rows_per_col = 4'h8;
    endcase
  endfunction

  function automatic logic [PTR_W-1:0] col_limit(input lcdr_mode_t mode);
    col_limit = (mode == MODE_SEX) ? PTR_W'(NUM_COLS) : PTR_W'(STD_COLS);
  endfunction

  function automatic logic [ROW_W-1:0] bank_row(input lcdr_mode_t mode, input logic bank);
    if (bank && (mode == MODE_STATIC || mode == MODE_DUP || mode == MODE_QUAD)) begin
      bank_row = BANK1_ROW;
    end else begin
      bank_row = 3'h0;
    end
  endfunction

endpackage

// File: test/lcdr_panel_model.sv
// Behavioural LCD glass that reads the active row back from the panel pins.
module lcdr_panel_model
  import lcdr_pkg::*;
(
  // Drive configuration and pins
  input wire lcdr_mode_t mode_i,
  input wire lcdr_pins_t pins_i,
  // Observed row
  output logic active_o,
  output logic [2:0] phase_o,
  output logic [45:0] row_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bp;
  int n;
  int hits;
  // The glass is wired only to the backplanes that the mode uses.
  always_comb begin
    bp = {pins_i.seg44_bp7, pins_i.seg45_bp6, pins_i.backplane};
    n = (mode_i == MODE_STATIC) ? 1 : (mode_i == MODE_DUP) ? 2 : (mode_i == MODE_QUAD) ? 4 :
        (mode_i == MODE_SEX) ? 6 : 8;
    hits = 0;
    phase_o = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (i < n && bp[i] === 1'b1) begin
        hits++;
        phase_o = 3'(i);
      end
    end
    active_o = (hits == 1);
    row_o = (n == 6) ? {pins_i.seg45_bp6, pins_i.seg44_bp7, pins_i.segment} :
        {2'h0, pins_i.segment};
  end
endmodule

// File: test/lcdr_display_map_tb.sv
// Self-checking bench for the display RAM write path and panel output map.
module lcdr_display_map_tb;
  import lcdr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RDIV = 4;
  typedef struct {
    logic [2:0] phase;
    logic [7:0] bp;
    logic [7:0] mask;
    logic [45:0] row;
  } lcdr_note_t;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  lcdr_mode_t mode = MODE_OCT;
  logic input_bank_select = 1'b0;
  logic output_bank_select = 1'b0;
  logic host_valid = 1'b0;
  lcdr_host_t host_word = '0;
  logic host_ready;
  lcdr_pins_t pins;
  logic active;
  logic [2:0] phase;
  logic [45:0] row;
  logic [7:0] bp_now;
  logic [45:0] ram [8] = '{default: '0};
  lcdr_note_t exp_q [$];
  int failures = 0;
  int n_tests = 0;
  int pos;
  int nrow;
  int lim;
  int roff;
  assign bp_now = {pins.seg44_bp7, pins.seg45_bp6, pins.backplane};
  always #50 clock_i = ~clock_i;
  lcdr_display_map #(.ROW_DIV(RDIV)) i_lcdr_display_map (.clock_i(clock_i),
    .resetn_i(resetn_i), .mode_i(mode), .input_bank_select_i(input_bank_select),
    .output_bank_select_i(output_bank_select), .host_valid_i(host_valid), .host_word_i(host_word),
    .host_ready_o(host_ready), .pins_o(pins));
  lcdr_panel_model i_lcdr_panel_model (.mode_i(mode), .pins_i(pins), .active_o(active),
    .phase_o(phase), .row_o(row));
  task automatic chk_row(input string what, input logic [45:0] exp, input logic [45:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Reference RAM: bit j of a byte, MSB first, lands at linear position pos + j.
  task automatic model_byte(input logic [7:0] v);
    for (int j = 0; j < 8; j++) begin
      if (pos < lim * nrow) begin
        ram[roff + pos % nrow][pos / nrow] = v[7 - j];
      end
      pos++;
    end
  endtask
  // Holds valid high across back-to-back words; the caller lowers it after a burst.
  task automatic send(input logic ld, input logic [7:0] v);
    int w;
    w = 0;
    host_valid = 1'b1;
    host_word = {ld, v};
    while (host_ready !== 1'b1 && w < 200) begin
      @(posedge clock_i);
      #1;
      w++;
    end
    @(posedge clock_i);
    #1;
    if (ld) begin
      pos = int'(v) * nrow;
    end else begin
      model_byte(v);
    end
  endtask
  task automatic run(input lcdr_mode_t m, input int n, input logic wb, input logic db);
    int col;
    lcdr_note_t e;
    mode = m;
    input_bank_select = wb;
    output_bank_select = db;
    nrow = n;
    lim = (m == MODE_SEX) ? 46 : 44;
    roff = (wb && n < 6) ? 4 : 0;
    col = $urandom_range(0, 5);
    send(1'b1, 8'(col));
    // Runs past the row end so that surplus bits and bytes must be dropped.
    for (int b = 0; b < ((lim - col) * n + 7) / 8 + 2; b++) begin
      send(1'b0, 8'($urandom));
    end
    host_valid = 1'b0;
    repeat (24 * RDIV + 30) @(posedge clock_i);
    for (int p = 0; p < n; p++) begin
      e.phase = 3'(p);
      e.mask = (n == 6) ? 8'h3F : 8'hFF;
      for (int i = 0; i < 8; i++) begin
        e.bp[i] = (n == 6) ? (i == p) : (i % n == p);
      end
      e.row = ram[p + ((db && n < 6) ? 4 : 0)];
      if (n != 6) begin
        e.row[45:44] = 2'h0;
      end
      exp_q.push_back(e);
    end
    for (int w = 0; w < 400 && exp_q.size() > 0; w++) begin
      @(posedge clock_i);
    end
    if (exp_q.size() > 0) begin
      failures++;
      $display("BAD phases expected %0d seen 0", exp_q.size());
      exp_q.delete();
    end
    #1;
    $display("Done rows %0d write bank %0d show bank %0d", n, wb, db);
  endtask
  // Nine words back to back through the top; their order shows later on the 1:8 rows.
  task automatic fifo_test();
    nrow = 8;
    lim = 44;
    roff = 0;
    chk_pin("ready_after_reset", 8'h1, {7'h0, host_ready});
    send(1'b1, 8'h00);
    for (int k = 0; k < 8; k++) begin
      chk_pin("fifo_ready", 8'h1, {7'h0, host_ready});
      send(1'b0, 8'($urandom));
    end
    host_valid = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    chk_pin("fifo_idle_ready", 8'h1, {7'h0, host_ready});
    $display("Done fifo fill and drain");
  endtask
  always @(negedge clock_i) begin
    if (exp_q.size() > 0 && active === 1'b1 && phase === exp_q[0].phase) begin
      chk_row("segments", exp_q[0].row, row);
      chk_pin("backplanes", exp_q[0].bp & exp_q[0].mask, bp_now & exp_q[0].mask);
      void'(exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h71E1AE90));
    repeat (6) @(posedge clock_i);
    #1;
    chk_pin("ready_in_reset", 8'h0, {7'h0, host_ready});
    chk_row("pins_in_reset", 46'h0, pins[45:0]);
    resetn_i = 1'b1;
    @(posedge clock_i);
    #1;
    fifo_test();
    run(MODE_OCT, 8, 1'b0, 1'b0);
    run(MODE_SEX, 6, 1'b0, 1'b0);
    for (int b = 0; b < 2; b++) begin
      run(MODE_STATIC, 1, b[0], b[0]);
      run(MODE_DUP, 2, b[0], b[0]);
      run(MODE_QUAD, 4, b[0], b[0]);
    end
    run(MODE_QUAD, 4, 1'b0, 1'b1);
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge clock_i);
    failures++;
    print_verdict();
  end
endmodule
